/* logic/icra_defs.vh */
// icra_defs.vh: offsets, field positions, reset values and codes of the
// indexed configuration register front end.
// assumes: included by bare name from design files under logic/.
`ifndef ICRA_DEFS_VH
`define ICRA_DEFS_VH

`define ICRA_INDEX_PORT 16'h0022
`define ICRA_DATA_PORT 16'h0023

`define ICRA_OFS_UNLOCK 8'h02
`define ICRA_OFS_STEPPING 8'h08
`define ICRA_OFS_MODE 8'h40

`define ICRA_UNLOCK_CODE 8'h0F
`define ICRA_UNLOCK_RST 8'h00
`define ICRA_MODE_RST 8'h20
`define ICRA_MODE_WMASK 8'h7F

`define ICRA_MODE_MUXEN_BIT 6
`define ICRA_MODE_CPG_BIT 5
`define ICRA_MODE_ECS_BIT 4
`define ICRA_MODE_SERR_BIT 3
`define ICRA_MODE_MAP_HI 2
`define ICRA_MODE_MAP_LO 0

`define ICRA_RESERVED_READ 8'h00

`endif

/* logic/icra_strap_capture.v */
// icra_strap_capture.v: catches the init/test role strap at reset release.
// assumes: strap pin is synchronous to core_clk; asynchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module icra_strap_capture (
  input wire core_clk,
  input wire rstn,
  input wire strap_in,
  output reg strap_taken_reg,
  output reg strap_value_reg
);
  // first clocked edge after release latches the level, then holds
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      strap_taken_reg <= 1'b0;
      strap_value_reg <= 1'b1;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      strap_value_reg <= strap_in;
    end
  end
endmodule // icra_strap_capture
`default_nettype wire

/* logic/icra_config_front.v */
// icra_config_front.v: index/data port configuration front end, unlock
// register, stepping register, mode select register and test tri-state.
// assumes: host i/o cycles are single-cycle strobes synchronous to core_clk.
//
// Operation
// - without power management, the combined pin is only test; low turns off the select and page address enables.
// - with power management, chip-select zero level at reset picks init or test role.
// - test role active and pin low turns off the select and page address enables and holds nmi and mux enable low.
// - reset loads every register with its default value.
// - read-only writes change nothing; reserved bits read-only; reads have no side effect.
// - index port decoded at 0022h, data port at 0023h.
// - data port accesses go to the register chosen by the index.
// - reserved locations complete the cycle, read zero, ignore writes.
// - unlock register at 02h must get 0Fh before other registers respond.
// - after reset only the unlock register responds until unlocked again.
// - stepping register returns a fixed value; writes are ignored.
// - mode register at 40h resets 20h; bit 6 enables the muxed pin function.
// - mode bit 5 enables page address on upper address lines for config ram.
// - strap captured at end of reset; pin then returns to chip-select duty.
// - mode bit 4 picks individual active-low selects or encoded select.
// - mode bit 3 gates nmi from pci system error pulses.
// - mode bits 2:0 pick the slot and x-bus pin sharing with pci interrupts.
`timescale 1ns/1ps
`default_nettype none
`include "icra_defs.vh"
module icra_config_front #(
  parameter POWER_MANAGED = 1,
  parameter [7:0] STEPPING_VALUE = 8'h00 // arbitrary stepping value
) (
  input wire core_clk,
  input wire rstn,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_wdata,
  output reg [7:0] io_rdata,
  output reg io_ack,
  input wire init_test_pin,
  input wire strap_chip_select_zero,
  input wire [2:0] cs_hit,
  input wire cfg_ram_access,
  input wire [4:0] cfg_ram_page,
  input wire serr_pulse,
  input wire nmi_global_en,
  output reg [2:0] general_chip_selects,
  output reg [2:0] general_chip_selects_oe,
  output reg [4:0] cfg_ram_page_addr,
  output reg cfg_ram_page_addr_oe,
  output reg serr_nmi,
  output reg pci_mux_enable,
  output reg [2:0] pci_mux_map,
  output reg cs_encoded_mode,
  output reg init_request,
  output reg outputs_floated
);

  ////////////////////////////////////////////////////////////////////////
  // strap capture
  // sampled once after reset; the pin then returns to select duty
  wire strap_taken;
  wire strap_value;

  icra_strap_capture u_strap (
    .core_clk(core_clk),
    .rstn(rstn),
    .strap_in(strap_chip_select_zero),
    .strap_taken_reg(strap_taken),
    .strap_value_reg(strap_value)
  );

  wire test_role = (POWER_MANAGED == 0) ? 1'b1 : strap_value;
  wire float_now = strap_taken && test_role && !init_test_pin;
  wire init_now = strap_taken && !test_role && !init_test_pin;

  ////////////////////////////////////////////////////////////////////////
  // register state
  reg [7:0] index_reg;
  reg [7:0] unlock_reg;
  reg [7:0] mode_reg;

  wire index_sel = (io_addr == `ICRA_INDEX_PORT);
  wire data_sel = (io_addr == `ICRA_DATA_PORT);
  // unlock compares the whole byte, so any other value relocks
  wire unlocked = (unlock_reg == `ICRA_UNLOCK_CODE);
  wire hit_unlock = (index_reg == `ICRA_OFS_UNLOCK);
  wire hit_mode = unlocked && (index_reg == `ICRA_OFS_MODE);
  wire hit_step = unlocked && (index_reg == `ICRA_OFS_STEPPING);
  wire index_wr = io_wr && index_sel;
  wire data_wr = io_wr && data_sel;
  wire any_strobe = io_wr || io_rd;
  wire any_access = any_strobe && (index_sel || data_sel);

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      index_reg <= 8'h00;
      unlock_reg <= `ICRA_UNLOCK_RST;
      mode_reg <= `ICRA_MODE_RST;
    end else begin
      if (index_wr) begin
        index_reg <= io_wdata;
      end
      if (data_wr && hit_unlock) begin
        unlock_reg <= io_wdata;
      end
      if (data_wr && hit_mode) begin
        mode_reg <= io_wdata & `ICRA_MODE_WMASK;
      end
      // stepping and reserved locations take no write
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data and cycle completion
  reg [7:0] rdata_next;

  always @* begin
    // reserved data reads, and locked reads other than the unlock register, fall through to zero
    rdata_next = `ICRA_RESERVED_READ;
    if (index_sel) begin
      // index port reads back the held offset
      rdata_next = index_reg;
    end else if (data_sel) begin
      if (hit_unlock) begin
        rdata_next = unlock_reg;
      end else if (hit_mode) begin
        rdata_next = mode_reg;
      end else if (hit_step) begin
        rdata_next = STEPPING_VALUE;
      end
    end
  end

  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      io_rdata <= 8'h00;
      io_ack <= 1'b0;
    end else begin
      // every decoded cycle completes, even when locked or reserved
      io_ack <= any_access;
      if (io_rd) begin
        io_rdata <= rdata_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // mode-steered outputs
  reg [2:0] cs_next;

  always @* begin
    if (mode_reg[`ICRA_MODE_ECS_BIT]) begin
      // encoded: highest hit wins, zero means no select
      cs_next = 3'h0;
      if (cs_hit[0]) begin
        cs_next = 3'h1;
      end
      if (cs_hit[1]) begin
        cs_next = 3'h2;
      end
      if (cs_hit[2]) begin
        cs_next = 3'h3;
      end
    end else begin
      cs_next = ~cs_hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // next enables and events; test float parks the select, page, nmi and mux enables off
  reg [2:0] cs_oe_next;
  reg page_oe_next;
  reg nmi_next;
  reg mux_next;
  reg init_next;
  reg float_next;

  always @* begin
    cs_oe_next = {3{strap_taken}};
    page_oe_next = cfg_ram_access && mode_reg[`ICRA_MODE_CPG_BIT];
    nmi_next = serr_pulse && nmi_global_en && mode_reg[`ICRA_MODE_SERR_BIT];
    mux_next = mode_reg[`ICRA_MODE_MUXEN_BIT];
    init_next = init_now;
    float_next = float_now;
    if (float_now) begin
      cs_oe_next = 3'h0;
      page_oe_next = 1'b0;
      nmi_next = 1'b0;
      mux_next = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      general_chip_selects <= 3'h7;
      general_chip_selects_oe <= 3'h0;
      cfg_ram_page_addr <= 5'h00;
      cfg_ram_page_addr_oe <= 1'b0;
      serr_nmi <= 1'b0;
      pci_mux_enable <= 1'b0;
      pci_mux_map <= 3'h0;
      cs_encoded_mode <= 1'b0;
      init_request <= 1'b0;
      outputs_floated <= 1'b0;
    end else begin
      general_chip_selects <= cs_next;
      general_chip_selects_oe <= cs_oe_next;
      cfg_ram_page_addr <= cfg_ram_page;
      cfg_ram_page_addr_oe <= page_oe_next;
      serr_nmi <= nmi_next;
      pci_mux_enable <= mux_next;
      pci_mux_map <= mode_reg[`ICRA_MODE_MAP_HI:`ICRA_MODE_MAP_LO];
      cs_encoded_mode <= mode_reg[`ICRA_MODE_ECS_BIT];
      init_request <= init_next;
      outputs_floated <= float_next;
    end
  end

endmodule // icra_config_front
`default_nettype wire

/* tb/icra_cfg_monitor.sv */
// icra_cfg_monitor.sv: port checks of the config front end.
// assumes: bound onto icra_config_front, single clock domain.
`timescale 1ns/1ps
`default_nettype none
module icra_cfg_monitor (
  input wire core_clk,
  input wire rstn,
  input wire [15:0] io_addr,
  input wire io_wr,
  input wire io_rd,
  input wire [7:0] io_rdata,
  input wire io_ack,
  input wire init_test_pin,
  input wire [2:0] cs_hit,
  input wire cfg_ram_access,
  input wire serr_pulse,
  input wire nmi_global_en,
  input wire [2:0] general_chip_selects,
  input wire [2:0] general_chip_selects_oe,
  input wire cfg_ram_page_addr_oe,
  input wire serr_nmi,
  input wire cs_encoded_mode,
  input wire init_request,
  input wire outputs_floated
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  wire hit = (io_wr | io_rd) && (io_addr == 16'h0022 || io_addr == 16'h0023);
  property p_ack; hit |=> io_ack; endproperty
  a_ack: assert property (p_ack) else $error("decoded cycle not acked");
  property p_noack; !hit |=> !io_ack; endproperty
  a_noack: assert property (p_noack) else $error("stray ack");
  property p_float;
    outputs_floated |-> general_chip_selects_oe == 3'h0 && !cfg_ram_page_addr_oe && !serr_nmi;
  endproperty
  a_float: assert property (p_float) else $error("enable left on while floated");
  property p_flt_cause; $rose(outputs_floated) |-> !$past(init_test_pin); endproperty
  a_flt_cause: assert property (p_flt_cause) else $error("float without pin low");
  property p_init; init_request |-> !outputs_floated; endproperty
  a_init: assert property (p_init) else $error("both pin roles active");
  property p_page; cfg_ram_page_addr_oe |-> $past(cfg_ram_access); endproperty
  a_page: assert property (p_page) else $error("page driven without access");
  property p_nmi; serr_nmi |-> $past(serr_pulse && nmi_global_en); endproperty
  a_nmi: assert property (p_nmi) else $error("nmi without cause");
  // first edge after reset still shows the reset level of the selects
  property p_cs;
    !cs_encoded_mode && $past(rstn) |-> general_chip_selects == ~$past(cs_hit);
  endproperty
  a_cs: assert property (p_cs) else $error("individual selects wrong");
  property p_rdata; $changed(io_rdata) |-> $past(io_rd); endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved without read");
endmodule // icra_cfg_monitor
bind icra_config_front icra_cfg_monitor i_mon (
  .core_clk(core_clk),
  .rstn(rstn),
  .io_addr(io_addr),
  .io_wr(io_wr),
  .io_rd(io_rd),
  .io_rdata(io_rdata),
  .io_ack(io_ack),
  .init_test_pin(init_test_pin),
  .cs_hit(cs_hit),
  .cfg_ram_access(cfg_ram_access),
  .serr_pulse(serr_pulse),
  .nmi_global_en(nmi_global_en),
  .general_chip_selects(general_chip_selects),
  .general_chip_selects_oe(general_chip_selects_oe),
  .cfg_ram_page_addr_oe(cfg_ram_page_addr_oe),
  .serr_nmi(serr_nmi),
  .cs_encoded_mode(cs_encoded_mode),
  .init_request(init_request),
  .outputs_floated(outputs_floated)
);
`default_nettype wire

/* tb/icra_host_model.sv */
// icra_host_model.sv: host master issuing single-strobe i/o cycles.
// assumes: strobes launched just after core_clk rising edges.
`timescale 1ns/1ps
`default_nettype none
module icra_host_model (
  input wire core_clk,
  input wire io_ack,
  input wire [7:0] io_rdata,
  output reg [15:0] io_addr,
  output reg io_wr,
  output reg io_rd,
  output reg [7:0] io_wdata
);
  initial begin
    io_addr = 16'h0000;
    io_wr = 1'b0;
    io_rd = 1'b0;
    io_wdata = 8'h00;
  end
  // idle write data inverted so stale values never match
  task acc(input [15:0] a, input [7:0] d, input w, output [7:0] q, output k);
    begin
      @(posedge core_clk);
      io_addr <= a;
      io_wdata <= d;
      io_wr <= w;
      io_rd <= !w;
      @(posedge core_clk);
      io_wr <= 1'b0;
      io_rd <= 1'b0;
      io_wdata <= ~d;
      @(negedge core_clk);
      q = io_rdata;
      k = io_ack;
    end
  endtask
endmodule // icra_host_model
`default_nettype wire

/* tb/test_indexed_config_register_access.sv */
// test_indexed_config_register_access.sv: directed test of the front end.
// assumes: host model drives the i/o strobes, bench drives the rest.
`timescale 1ns/1ps
`default_nettype none
module test_indexed_config_register_access;
  reg core_clk = 1'b0;
  reg rstn = 1'b0;
  reg pin = 1'b1;
  reg strap = 1'b1;
  reg [2:0] cs_hit = 3'h0;
  reg cra = 1'b0;
  reg serr = 1'b0;
  reg nmien = 1'b0;
  wire [15:0] io_addr;
  wire io_wr, io_rd, io_ack, pg_oe, nmi, mux, enc, initr, flt;
  wire [7:0] io_wdata, io_rdata;
  wire [2:0] gcs, gcs_oe, map;
  wire [4:0] pg;
  wire flt2, initr2;
  localparam [7:0] STEP_VALUE = 8'hC3; // arbitrary stepping value
  integer n_fail = 0;
  integer checked = 0;
  integer cyc = 0;
  reg [7:0] q;
  reg k;
  always #5 core_clk = ~core_clk;
  icra_host_model i_host (.core_clk(core_clk), .io_ack(io_ack), .io_rdata(io_rdata), .io_addr(io_addr),
    .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));
  icra_config_front #(.POWER_MANAGED(0), .STEPPING_VALUE(STEP_VALUE)) i_dut_test_only (.core_clk(core_clk),
    .rstn(rstn), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata), .io_rdata(), .io_ack(),
    .init_test_pin(pin), .strap_chip_select_zero(strap), .cs_hit(cs_hit), .cfg_ram_access(cra),
    .cfg_ram_page(5'h15), .serr_pulse(serr), .nmi_global_en(nmien), .general_chip_selects(),
    .general_chip_selects_oe(), .cfg_ram_page_addr(), .cfg_ram_page_addr_oe(), .serr_nmi(), .pci_mux_enable(),
    .pci_mux_map(), .cs_encoded_mode(), .init_request(initr2), .outputs_floated(flt2));
  icra_config_front #(.POWER_MANAGED(1), .STEPPING_VALUE(STEP_VALUE)) i_dut (.core_clk(core_clk), .rstn(rstn),
    .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
    .io_wdata(io_wdata), .io_rdata(io_rdata), .io_ack(io_ack), .init_test_pin(pin), .strap_chip_select_zero(strap),
    .cs_hit(cs_hit), .cfg_ram_access(cra), .cfg_ram_page(5'h15), .serr_pulse(serr), .nmi_global_en(nmien),
    .general_chip_selects(gcs), .general_chip_selects_oe(gcs_oe), .cfg_ram_page_addr(pg),
    .cfg_ram_page_addr_oe(pg_oe), .serr_nmi(nmi), .pci_mux_enable(mux), .pci_mux_map(map),
    .cs_encoded_mode(enc), .init_request(initr), .outputs_floated(flt));
  task close_out;
    begin
      if (n_fail == 0 && checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task w(input [7:0] i, input [7:0] d);
    begin
      i_host.acc(16'h0022, i, 1'b1, q, k);
      chk({7'h00, k}, 8'h01);
      i_host.acc(16'h0023, d, 1'b1, q, k);
      chk({7'h00, k}, 8'h01);
    end
  endtask
  task r(input [7:0] i, input [7:0] e);
    begin
      i_host.acc(16'h0022, i, 1'b1, q, k);
      i_host.acc(16'h0023, 8'h00, 1'b0, q, k);
      chk(q, e);
    end
  endtask
  always @(posedge core_clk) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      n_fail = n_fail + 1;
      close_out;
    end
  end
  initial begin
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    r(8'h02, 8'h00);
    w(8'h40, 8'h55);
    r(8'h40, 8'h00);
    w(8'h02, 8'h0E);
    r(8'h02, 8'h0E);
    r(8'h40, 8'h00);
    w(8'h02, 8'h0F);
    r(8'h40, 8'h20);
    i_host.acc(16'h0023, 8'h00, 1'b0, q, k);
    chk(q, 8'h20);
    w(8'h40, q | 8'hDF);
    r(8'h40, 8'h7F);
    chk({3'h0, mux, enc, map}, 8'h1F);
    w(8'h08, 8'h5A);
    r(8'h08, STEP_VALUE);
    w(8'h10, 8'hAA);
    r(8'h10, 8'h00);
    i_host.acc(16'h0024, 8'h00, 1'b1, q, k);
    chk({7'h00, k}, 8'h00);
    @(posedge core_clk);
    {cs_hit, cra, nmien, serr} <= 6'h37;
    @(posedge core_clk);
    serr <= 1'b0;
    @(negedge core_clk);
    chk({nmi, pg_oe, gcs_oe, gcs}, 8'hFB);
    chk({3'h0, pg}, 8'h15);
    w(8'h40, 8'h00);
    @(negedge core_clk);
    chk({3'h0, mux, pg_oe, gcs}, 8'h01);
    @(posedge core_clk);
    pin <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk({3'h0, flt, initr, gcs_oe}, 8'h10);
    @(posedge core_clk);
    {pin, rstn, strap} <= 3'h4;
    repeat (2) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    pin <= 1'b0;
    @(posedge core_clk);
    @(negedge core_clk);
    chk({6'h00, flt, initr}, 8'h01);
    chk({6'h00, flt2, initr2}, 8'h02);
    r(8'h40, 8'h00);
    close_out;
  end
endmodule // test_indexed_config_register_access
`default_nettype wire
